// File: src/mpxa_params.svh
`ifndef MPXA_PARAMS_SVH
`define MPXA_PARAMS_SVH
// Port counts and widths
`define MPXA_N_MASTERS      7
`define MPXA_N_SLAVES       8
`define MPXA_ADDR_W         32
`define MPXA_DATA_W         64
// Priority field width per master
`define MPXA_PRIO_W         3
// Reset values of the mode control and of each arbiter's last-owner pointer
`define MPXA_RST_MODE       1'b0
`define MPXA_RST_LAST       3'h6
// Slave select field: address bits [31:29]
`define MPXA_SEL_LSB        29
`define MPXA_SEL_W          3
`endif

// File: src/mpxa_pkg.sv
package mpxa_pkg;
    // Arbitration scheme chosen by software
    typedef enum logic {
        MPXA_MODE_RR    = 1'b0,
        MPXA_MODE_FIXED = 1'b1
    } mpxa_mode_t;
    // Per-slave ownership state, Gray along idle-own
    typedef enum logic {
        MPXA_IDLE = 1'b0,
        MPXA_OWN  = 1'b1
    } mpxa_state_t;
endpackage

// File: src/mpxa_slave_arb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpxa_params.svh"
// One arbiter per slave port; owner held until the burst ends or its request drops
module mpxa_slave_arb #(
    parameter int NM = `MPXA_N_MASTERS,
    parameter int PW = `MPXA_PRIO_W
) (
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire logic [NM-1:0]           req,
    input  wire logic [NM-1:0]           done,
    input  wire logic                    mode,
    input  wire logic [NM*PW-1:0]        prio,
    input  wire logic [NM-1:0]           elevate,
    output logic      [NM-1:0]           grant
);
    localparam int IW = $clog2(NM);

    // Parameter check at elaboration
    if (NM < 2 || PW < 1) begin : g_bad_par
        $error("mpxa_slave_arb: needs two masters and a priority field");
    end

    mpxa_pkg::mpxa_state_t state_r, state_nxt;
    logic [IW-1:0]  owner_r, owner_nxt;
    logic [IW-1:0]  last_r, last_nxt;
    logic           found;
    logic [IW-1:0]  pick;
    logic [PW:0]    best;
    logic [PW:0]    eff;
    logic [IW-1:0]  idx;

    // Winner search: highest effective level, rotating from last owner
    always_comb begin
        found = 1'b0;
        pick  = '0;
        best  = '0;
        eff   = '0;
        idx   = '0;
        for (int k = 1; k <= NM; k++) begin
            idx = IW'((int'(last_r) + k) % NM);
            if (mode == mpxa_pkg::MPXA_MODE_FIXED)
                eff = {elevate[idx], prio[idx*PW +: PW]};
            else
                eff = {elevate[idx], {PW{1'b0}}};
            // Strict > keeps the first in rotation among equals
            if (req[idx] && (!found || eff > best)) begin
                found = 1'b1;
                best  = eff;
                pick  = idx;
            end
        end
    end

    // Next ownership; re-arbitrate only at a burst end or when the owner drops its request
    always_comb begin
        state_nxt = state_r;
        owner_nxt = owner_r;
        last_nxt  = last_r;
        unique case (state_r)
            mpxa_pkg::MPXA_IDLE: begin
                if (found) begin
                    state_nxt = mpxa_pkg::MPXA_OWN;
                    owner_nxt = pick;
                    last_nxt  = pick;
                end
            end
            mpxa_pkg::MPXA_OWN: begin
                if (done[owner_r] || !req[owner_r])
                    state_nxt = mpxa_pkg::MPXA_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= mpxa_pkg::MPXA_IDLE;
            owner_r <= '0;
            last_r  <= IW'(`MPXA_RST_LAST);
        end else begin
            state_r <= state_nxt;
            owner_r <= owner_nxt;
            last_r  <= last_nxt;
        end
    end

    // One-hot grant to the owner; others stay stalled
    always_comb begin
        grant = '0;
        if (state_r == mpxa_pkg::MPXA_OWN)
            grant[owner_r] = 1'b1;
    end
endmodule
`default_nettype wire

// File: src/mpxa_crossbar_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpxa_params.svh"
// How it works
// - When several masters want one slave, the higher-priority master gets it.
// - Losers stay stalled until the owner has finished on that slave.
// - Equal-priority requesters are served round-robin starting after the last granted id.
// - Different masters reach different slaves at the same time through separate paths.
// - Seven master ports and eight slave ports, any master to any slave.
// - Every port has a 32-bit address and 64-bit data path.
// - Software picks equal round-robin priority or an explicit priority order at run time.
// - A master can be raised above its programmed level while elevation is asked.
module mpxa_crossbar_switch #(
    parameter int NM = `MPXA_N_MASTERS,
    parameter int NS = `MPXA_N_SLAVES,
    parameter int AW = `MPXA_ADDR_W,
    parameter int DW = `MPXA_DATA_W,
    parameter int PW = `MPXA_PRIO_W
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // Master side
    input  wire logic [NM-1:0]       m_req,
    input  wire logic [NM-1:0]       m_last,
    input  wire logic [NM-1:0]       m_write,
    input  wire logic [NM*AW-1:0]    m_addr,
    input  wire logic [NM*DW-1:0]    m_wdata,
    output logic      [NM*DW-1:0]    m_rdata,
    output logic      [NM-1:0]       m_ready,
    // Slave side
    output logic      [NS-1:0]       s_sel,
    output logic      [NS-1:0]       s_write,
    output logic      [NS*AW-1:0]    s_addr,
    output logic      [NS*DW-1:0]    s_wdata,
    input  wire logic [NS*DW-1:0]    s_rdata,
    input  wire logic [NS-1:0]       s_ready,
    // Arbitration controls (no register bus)
    input  wire logic                arb_mode,
    input  wire logic [NM*PW-1:0]    arb_prio,
    input  wire logic [NM-1:0]       arb_elevate
);
    localparam int IW = $clog2(NM);
    localparam int SW = `MPXA_SEL_W;

    // Parameter checks at elaboration
    if (NM < 2) begin : g_bad_nm
        $error("mpxa_crossbar_switch: at least two masters are needed");
    end
    if (NS < 1 || NS > (1 << SW)) begin : g_bad_ns
        $error("mpxa_crossbar_switch: slave count does not fit the select field");
    end
    if (PW < 1) begin : g_bad_pw
        $error("mpxa_crossbar_switch: priority field must be at least one bit");
    end
    if (AW < `MPXA_SEL_LSB + SW) begin : g_bad_aw
        $error("mpxa_crossbar_switch: address too narrow for the slave select");
    end
    if (DW < 1) begin : g_bad_dw
        $error("mpxa_crossbar_switch: data path must be at least one bit");
    end

    // Registered arbitration controls
    mpxa_pkg::mpxa_mode_t mode_r, mode_nxt;
    logic [NM*PW-1:0]     prio_r, prio_nxt;
    logic [NM-1:0]        elev_r, elev_nxt;
    // Routing and arbitration
    logic [SW-1:0]        route [NM];
    logic [NM-1:0]        req_mat [NS];
    logic [NM-1:0]        done_mat [NS];
    logic [NM-1:0]        grant [NS];
    logic [NS-1:0]        owned;
    logic [IW-1:0]        owner_idx [NS];
    // Output next values
    logic [NS-1:0]        s_sel_nxt, s_write_nxt;
    logic [NS*AW-1:0]     s_addr_nxt;
    logic [NS*DW-1:0]     s_wdata_nxt;
    logic [NM*DW-1:0]     m_rdata_nxt;
    logic [NM-1:0]        m_ready_nxt;

    // Software controls pass one register stage, off the search path
    always_comb begin
        mode_nxt = mpxa_pkg::mpxa_mode_t'(arb_mode);
        prio_nxt = arb_prio;
        elev_nxt = arb_elevate;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= mpxa_pkg::mpxa_mode_t'(`MPXA_RST_MODE);
            prio_r <= '0;
            elev_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            prio_r <= prio_nxt;
            elev_r <= elev_nxt;
        end
    end

    // Slave index named by each master's top address bits
    always_comb begin
        for (int m = 0; m < NM; m++) begin
            route[m] = m_addr[m*AW+`MPXA_SEL_LSB +: SW];
        end
    end

    // Request and burst-end matrices, one row per slave
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            for (int m = 0; m < NM; m++) begin
                req_mat[s][m]  = m_req[m] && (int'(route[m]) == s);
                done_mat[s][m] = req_mat[s][m] && m_last[m] && s_ready[s]
                                 && grant[s][m];
            end
        end
    end

    // One independent arbiter per slave port
    for (genvar s = 0; s < NS; s++) begin : g_arb
        mpxa_slave_arb #(
            .NM (NM),
            .PW (PW)
        ) u_arb (
            .core_clk (core_clk),
            .rstn     (rstn),
            .req      (req_mat[s]),
            .done     (done_mat[s]),
            .mode     (mode_r),
            .prio     (prio_r),
            .elevate  (elev_r),
            .grant    (grant[s])
        );
    end

    // Owner index per slave; a dropped request frees the slave at once
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            owned[s]     = 1'b0;
            owner_idx[s] = '0;
            for (int m = 0; m < NM; m++) begin
                if (grant[s][m] && req_mat[s][m]) begin
                    owned[s]     = 1'b1;
                    owner_idx[s] = IW'(m);
                end
            end
        end
    end

    // Slave side: owner's request signals, zero while unowned
    always_comb begin
        s_sel_nxt   = '0;
        s_write_nxt = '0;
        s_addr_nxt  = '0;
        s_wdata_nxt = '0;
        for (int s = 0; s < NS; s++) begin
            if (owned[s]) begin
                s_sel_nxt[s]            = 1'b1;
                s_write_nxt[s]          = m_write[owner_idx[s]];
                s_addr_nxt[s*AW +: AW]  = m_addr[owner_idx[s]*AW +: AW];
                s_wdata_nxt[s*DW +: DW] = m_wdata[owner_idx[s]*DW +: DW];
            end
        end
    end

    // Slave-side output registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_sel   <= '0;
            s_write <= '0;
            s_addr  <= '0;
            s_wdata <= '0;
        end else begin
            s_sel   <= s_sel_nxt;
            s_write <= s_write_nxt;
            s_addr  <= s_addr_nxt;
            s_wdata <= s_wdata_nxt;
        end
    end

    // Master side: answer of the owned slave; losers see not-ready
    always_comb begin
        m_rdata_nxt = '0;
        m_ready_nxt = '0;
        for (int m = 0; m < NM; m++) begin
            for (int s = 0; s < NS; s++) begin
                if (owned[s] && owner_idx[s] == IW'(m)) begin
                    m_rdata_nxt[m*DW +: DW] = s_rdata[s*DW +: DW];
                    m_ready_nxt[m]          = s_ready[s];
                end
            end
        end
    end

    // Master-side output registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            m_rdata <= '0;
            m_ready <= '0;
        end else begin
            m_rdata <= m_rdata_nxt;
            m_ready <= m_ready_nxt;
        end
    end
endmodule
`default_nettype wire

// File: sim/mpxa_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory-side slaves, answering at once or held off by stall
module mpxa_slave_model #(
    parameter int NS = 8,
    parameter int DW = 64
) (
    input  wire logic               core_clk,
    input  wire logic [NS-1:0]      s_sel,
    input  wire logic [NS-1:0]      stall,
    output logic      [NS-1:0]      s_ready,
    output logic      [NS*DW-1:0]   s_rdata
);
    logic [7:0] cnt = 8'h00;
    // Idle data pattern changes every cycle
    always_ff @(posedge core_clk) cnt <= cnt + 8'h01;
    assign s_ready = s_sel & ~stall;
    for (genvar i = 0; i < NS; i++) begin : g_s
        assign s_rdata[i*DW+:DW] = s_ready[i] ? {(DW/8){8'(i)}} : {(DW/8){cnt}};
    end
endmodule
`default_nettype wire

// File: sim/mpxa_crossbar_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on ownership and stalls
module mpxa_crossbar_checker #(
    parameter int NM = 7,
    parameter int NS = 8,
    parameter int AW = 32
) (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic [NM-1:0]      m_req,
    input  wire logic [NM-1:0]      m_ready,
    input  wire logic [NS-1:0]      s_sel,
    input  wire logic [NS-1:0]      s_write,
    input  wire logic [NS*AW-1:0]   s_addr,
    input  wire logic [NS-1:0]      s_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sel_needs_req_a: assert property (s_sel != 0 |-> $past(m_req) != 0)
        else $error("slave selected with no request");
    grant_lat_a: assert property ($rose(|s_sel) |-> $past(m_req, 2) != 0)
        else $error("select rose too early");
    ready_lag_a: assert property (|m_ready |-> $past(|s_ready))
        else $error("master ready with no slave ready");
    ready_cnt_a: assert property ($countones(m_ready) <= $countones($past(s_sel & s_ready)))
        else $error("more masters ready than owners");
    sel_cap_a: assert property ($countones(s_sel) <= NM)
        else $error("more owners than masters");
    for (genvar i = 0; i < NS; i++) begin : g_h
        hold_addr_a: assert property (s_sel[i] && $past(s_sel[i] && !s_ready[i]) |->
            $stable(s_addr[i*AW+:AW])) else $error("burst address changed");
        hold_write_a: assert property (s_sel[i] && $past(s_sel[i] && !s_ready[i]) |->
            $stable(s_write[i])) else $error("burst direction changed");
    end
    cover property (s_sel[2] && s_sel[3]);
    cover property ($countones(m_req) > 1 && |m_ready);
    cover property ($fell(|s_sel));
    cover property ($fell(s_sel[6]) ##1 s_sel[6]);
endmodule
bind mpxa_crossbar_switch mpxa_crossbar_checker #(.NM(NM), .NS(NS), .AW(AW)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .m_req(m_req), .m_ready(m_ready), .s_sel(s_sel),
    .s_write(s_write), .s_addr(s_addr), .s_ready(s_ready));
`default_nettype wire

// File: sim/multi_port_crossbar_arbiter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module multi_port_crossbar_arbiter_bench;
    logic core_clk, rstn, arb_mode;
    logic [6:0] m_req, m_last, m_write, m_ready, arb_elevate;
    logic [7:0] s_sel, s_write, s_ready, stall;
    logic [223:0] m_addr;
    logic [255:0] s_addr;
    logic [447:0] m_wdata, m_rdata;
    logic [511:0] s_wdata, s_rdata;
    logic [20:0] arb_prio;
    int n_errors = 0;
    int compares = 0;
    mpxa_crossbar_switch dut (.core_clk(core_clk), .rstn(rstn), .m_req(m_req),
        .m_last(m_last), .m_write(m_write), .m_addr(m_addr), .m_wdata(m_wdata),
        .m_rdata(m_rdata), .m_ready(m_ready), .s_sel(s_sel), .s_write(s_write),
        .s_addr(s_addr), .s_wdata(s_wdata), .s_rdata(s_rdata), .s_ready(s_ready),
        .arb_mode(arb_mode), .arb_prio(arb_prio), .arb_elevate(arb_elevate));
    mpxa_slave_model u_slv (.core_clk(core_clk), .s_sel(s_sel), .stall(stall),
        .s_ready(s_ready), .s_rdata(s_rdata));
    // Bench helpers
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_sel(input int sl);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            #1;
            if (s_sel[sl] === 1'b1) break;
        end
        if (s_sel[sl] !== 1'b1) begin
            chk(0, "no grant");
            tally_and_finish();
        end
    endtask
    // All masters in mk contend for slave sl; exp must win
    task automatic contend(input logic [6:0] mk, input int sl, input int exp);
        logic [223:0] a;
        logic [447:0] w;
        for (int m = 0; m < 7; m++) begin
            a[m*32+:32] = {sl[2:0], 26'h0, m[2:0]};
            w[m*64+:64] = {8{4'hb, m[3:0]}};
        end
        @(posedge core_clk);
        m_addr <= a;
        m_wdata <= w;
        m_req <= mk;
        m_write <= mk & 7'h55;
        stall <= 8'hff;
        wait_sel(sl);
        chk(s_addr[sl*32+:3] === exp[2:0], "wrong owner");
        chk(s_write[sl] === (exp % 2 == 0), "wrong direction");
        chk(s_wdata[sl*64+:64] === {8{4'hb, exp[3:0]}}, "wrong write data");
        chk(m_ready === 7'h00, "ready while slave stalls");
        @(posedge core_clk);
        stall <= 8'h00;
        repeat (2) @(posedge core_clk);
        #1;
        chk(m_ready === 7'(1 << exp), "loser not stalled");
        chk(m_rdata[exp*64+:64] === {8{8'(sl)}}, "wrong read data");
        chk(s_addr[sl*32+:3] === exp[2:0], "burst split");
        @(posedge core_clk);
        m_req <= 7'h00;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic t_conc();
        @(posedge core_clk);
        m_addr <= {160'h0, 3'h3, 29'h1, 3'h2, 29'h0};
        m_req <= 7'h03;
        wait_sel(2);
        chk(s_sel[3] === 1'b1 && s_addr[64+:32] === 32'h40000000, "no concurrency");
        chk(s_addr[96+:32] === 32'h60000001, "wrong route");
        @(posedge core_clk);
        m_req <= 7'h00;
        repeat (3) @(posedge core_clk);
        $display("t_conc done");
    endtask
    task automatic t_fixed();
        arb_mode <= 1'b1;
        arb_prio <= 21'h000a40;
        contend(7'h0c, 0, 3);
        $display("t_fixed done");
    endtask
    task automatic t_rr();
        arb_mode <= 1'b0;
        contend(7'h09, 1, 0);
        contend(7'h09, 1, 3);
        $display("t_rr done");
    endtask
    task automatic t_elev();
        arb_mode <= 1'b1;
        arb_prio <= 21'h018000;
        arb_elevate <= 7'h10;
        contend(7'h30, 4, 4);
        arb_elevate <= 7'h00;
        contend(7'h30, 4, 5);
        $display("t_elev done");
    endtask
    // Burst end on the last beat hands the slave to the waiting master
    task automatic t_burst();
        @(posedge core_clk);
        m_addr <= {160'h0, 3'h6, 29'h1, 3'h6, 29'h0};
        m_req <= 7'h03;
        m_last <= 7'h00;
        wait_sel(6);
        chk(s_addr[192+:32] === 32'hc0000000, "burst owner");
        @(posedge core_clk);
        m_last <= 7'h01;
        #1;
        chk(m_ready === 7'h01, "loser not stalled in burst");
        @(posedge core_clk);
        m_req <= 7'h02;
        m_last <= 7'h00;
        @(posedge core_clk);
        #1;
        chk(s_sel[6] === 1'b0, "no gap after burst end");
        @(posedge core_clk);
        #1;
        chk(s_sel[6] === 1'b1 && s_addr[192+:32] === 32'hc0000001, "no handoff");
        @(posedge core_clk);
        m_req <= 7'h00;
        repeat (3) @(posedge core_clk);
        $display("t_burst done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {rstn, arb_mode, m_req, m_last, m_write, arb_elevate, stall} = '0;
        {m_addr, arb_prio} = '0;
        m_wdata = {56{8'ha5}};
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        t_conc();
        t_fixed();
        t_rr();
        t_elev();
        t_burst();
        tally_and_finish();
    end
endmodule
`default_nettype wire
